//--- rtl/ssq_pkg.sv
// Constants and types shared by the slot sequencer files
// How it works
// - 12-bit mode: result bits 11 down to 0 all carry data.
// - 10-bit mode: data on bits 11 to 2, bits 1 and 0 zero.
// - 8-bit mode: data on bits 11 to 4, bits 3 to 0 zero.
// - One program of 64 slots shared by every procedure.
// - Converter is driven one channel at a time in slot order.
// - After reset execution starts at slot 0, the default procedure.
// - Sample converts the slot's channel, then goes to the next slot.
// - Sample-and-jump converts, then continues at the named start slot.
// - Calibrate lasts 3840 converter clocks, then goes to the next slot.
// - Calibrate-and-jump calibrates, then continues at the named slot.
// - Jump converts nothing and goes straight to the named slot.
// - Power-down stops the converter; calibrate again before sampling.
// - Stop halts until an external trigger or jump request.
// - Idle slot op only uses its slot time, then advances.
// - Trigger and jump inputs always exist but act only when HAS_EXT_CTRL is set.
// - Jump request finishes the current slot, then goes to the target.
// - In automatic mode slot 63 is followed by slot 0.
package ssq_pkg;
    // ***************************************************
    // Widths
    // ***************************************************
    localparam int SLOT_COUNT = 64;
    localparam int SLOT_W = 6;
    localparam int CHAN_W = 5;
    localparam int RES_W = 12;
    localparam int OP_W = 3;
    localparam int WORD_W = 14;
    localparam int CAL_CNT_W = 16;

    // ***************************************************
    // Slot word layout
    // ***************************************************
    localparam int OP_LSB = 11;
    localparam int CHAN_LSB = 6;
    localparam int TARGET_LSB = 0;

    // ***************************************************
    // Operation codes
    // ***************************************************
    localparam logic [OP_W-1:0] OP_SAMPLE = 3'h0;
    localparam logic [OP_W-1:0] OP_SAMPLE_JUMP = 3'h1;
    localparam logic [OP_W-1:0] OP_CALIBRATE = 3'h2;
    localparam logic [OP_W-1:0] OP_CALIBRATE_JUMP = 3'h3;
    localparam logic [OP_W-1:0] OP_JUMP = 3'h4;
    localparam logic [OP_W-1:0] OP_POWER_DOWN = 3'h5;
    localparam logic [OP_W-1:0] OP_STOP = 3'h6;
    localparam logic [OP_W-1:0] OP_IDLE_SLOT = 3'h7;

    // ***************************************************
    // Resolution modes and masks
    // ***************************************************
    localparam logic [1:0] RES_MODE_12 = 2'h0;
    localparam logic [1:0] RES_MODE_10 = 2'h1;
    localparam logic [1:0] RES_MODE_8 = 2'h2;
    localparam logic [RES_W-1:0] MASK_12 = 12'hFFF;
    localparam logic [RES_W-1:0] MASK_10 = 12'hFFC;
    localparam logic [RES_W-1:0] MASK_8 = 12'hFF0;

    // ***************************************************
    // Reset values and timing
    // ***************************************************
    localparam logic [SLOT_W-1:0] RESET_SLOT = 6'h00;
    localparam logic [SLOT_W-1:0] SLOT_STEP = 6'h01;
    localparam logic [RES_W-1:0] RESULT_RESET = 12'h000;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 5'h00;
    localparam logic [CAL_CNT_W-1:0] CAL_CNT_ONE = 16'h0001;
    localparam logic [CAL_CNT_W-1:0] CAL_CNT_RESET = 16'h0000;
    localparam int CAL_ADC_CLOCKS = 3840;
    localparam int ADC_CLK_DIV = 4;

    // ***************************************************
    // Sequencer states
    // ***************************************************
    typedef enum logic [2:0] {
        ST_ISSUE,
        ST_CONVERT,
        ST_CALIBRATE,
        ST_FINISH,
        ST_WAIT_TRIG,
        ST_HALTED
    } ssq_state_e;
endpackage

//--- rtl/ssq_res_if.sv
// Carrier between the sequencer and its result formatter
`timescale 1ns/1ns
interface ssq_res_if;
    import ssq_pkg::*;
    logic [RES_W-1:0] rawData;
    logic [1:0] resMode;
    logic load;
    logic [RES_W-1:0] result;
    logic valid;

    modport producer (
        output rawData,
        output resMode,
        output load,
        input result,
        input valid
    );
    modport formatter (
        input rawData,
        input resMode,
        input load,
        output result,
        output valid
    );
endinterface

//--- rtl/ssq_result_fmt.sv
// Result formatter: masks converter data by resolution mode
`timescale 1ns/1ns
module ssq_result_fmt
    import ssq_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // Result carrier
    ssq_res_if.formatter res
);
    logic [RES_W-1:0] result_reg;
    logic [RES_W-1:0] result_next;
    logic valid_reg;
    logic valid_next;
    logic [RES_W-1:0] mask;

    always_comb begin
        mask = MASK_12;
        if (res.resMode == RES_MODE_10) begin
            mask = MASK_10;
        end else if (res.resMode == RES_MODE_8) begin
            mask = MASK_8;
        end else begin
            mask = MASK_12;
        end
        result_next = result_reg;
        valid_next = 1'b0;
        if (res.load) begin
            result_next = res.rawData & mask;
            valid_next = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            result_reg <= RESULT_RESET;
            valid_reg <= 1'b0;
        end else if (ce) begin
            result_reg <= result_next;
            valid_reg <= valid_next;
        end
    end

    assign res.result = result_reg;
    assign res.valid = valid_reg;
endmodule // ssq_result_fmt

//--- rtl/ssq_slot_sequencer.sv
// Top of the converter slot sequencer
`timescale 1ns/1ns
module ssq_slot_sequencer
    import ssq_pkg::*;
#(
    parameter logic HAS_EXT_CTRL = 1'b1,
    parameter int CAL_CYCLES = CAL_ADC_CLOCKS * ADC_CLK_DIV
) (
    // Clock, reset and clock enable
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // Program load port
    input wire logic progWrEn,
    input wire logic [SLOT_W-1:0] progWrAddr,
    input wire logic [WORD_W-1:0] progWrData,
    // User control
    input wire logic [1:0] resMode,
    input wire logic manualMode,
    input wire logic extTrigger,
    input wire logic branchRequest,
    input wire logic [SLOT_W-1:0] jumpTargetSlot,
    // Converter side
    input wire logic adcDone,
    input wire logic [RES_W-1:0] adcData,
    output logic adcStart,
    output logic [CHAN_W-1:0] adcChannel,
    output logic adcCalibrate,
    output logic adcPowerDown,
    // Status and results
    output logic [SLOT_W-1:0] slotNumber,
    output logic slotDone,
    output logic sampleActive,
    output logic halted,
    output logic [RES_W-1:0] conversionResult,
    output logic resultValid
);
    localparam logic [CAL_CNT_W-1:0] CAL_LOAD = CAL_CNT_W'(CAL_CYCLES);

    // ***************************************************
    // Program memory
    // ***************************************************
    // sixty-four slots
    logic [WORD_W-1:0] progMem [SLOT_COUNT];

    always_ff @(posedge clock) begin
        if (ce && progWrEn) begin
            progMem[progWrAddr] <= progWrData;
        end
    end

    // ***************************************************
    // State
    // ***************************************************
    ssq_state_e state_reg;
    ssq_state_e state_next;
    logic [SLOT_W-1:0] slot_reg;
    logic [SLOT_W-1:0] slot_next;
    logic [SLOT_W-1:0] follow_reg;
    logic [SLOT_W-1:0] follow_next;
    logic haltAfter_reg;
    logic haltAfter_next;
    logic powered_reg;
    logic powered_next;
    logic pendJump_reg;
    logic pendJump_next;
    logic [SLOT_W-1:0] pendTarget_reg;
    logic [SLOT_W-1:0] pendTarget_next;
    logic [CAL_CNT_W-1:0] calCnt_reg;
    logic [CAL_CNT_W-1:0] calCnt_next;
    logic adcStart_reg;
    logic adcStart_next;
    logic [CHAN_W-1:0] adcChannel_reg;
    logic [CHAN_W-1:0] adcChannel_next;
    logic adcCalibrate_reg;
    logic adcCalibrate_next;
    logic adcPowerDown_reg;
    logic adcPowerDown_next;
    logic slotDone_reg;
    logic slotDone_next;
    logic sampleActive_reg;
    logic sampleActive_next;
    logic halted_reg;
    logic halted_next;

    // ***************************************************
    // Slot decode
    // ***************************************************
    logic [WORD_W-1:0] slotWord;
    logic [OP_W-1:0] slotOp;
    logic [CHAN_W-1:0] slotChan;
    logic [SLOT_W-1:0] slotTarget;
    logic [SLOT_W-1:0] slotPlusOne;
    logic trigEff;
    logic branchEff;
    logic jumpWanted;
    logic [SLOT_W-1:0] jumpSlot;

    assign slotWord = progMem[slot_reg];
    assign slotOp = slotWord[OP_LSB +: OP_W];
    assign slotChan = slotWord[CHAN_LSB +: CHAN_W];
    assign slotTarget = slotWord[TARGET_LSB +: SLOT_W];
    assign slotPlusOne = slot_reg + SLOT_STEP;

    assign trigEff = HAS_EXT_CTRL & extTrigger;
    assign branchEff = HAS_EXT_CTRL & branchRequest;

    assign jumpWanted = branchEff | pendJump_reg;
    assign jumpSlot = branchEff ? jumpTargetSlot : pendTarget_reg;

    // ***************************************************
    // Result formatter
    // ***************************************************
    ssq_res_if resBus ();

    ssq_result_fmt uFmt (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .res(resBus.formatter)
    );

    assign resBus.rawData = adcData;
    assign resBus.resMode = resMode;
    assign resBus.load = (state_reg == ST_CONVERT) && adcDone && !powered_reg;

    // ***************************************************
    // Next state
    // ***************************************************
    always_comb begin
        state_next = state_reg;
        slot_next = slot_reg;
        follow_next = follow_reg;
        haltAfter_next = haltAfter_reg;
        powered_next = powered_reg;
        pendJump_next = pendJump_reg;
        pendTarget_next = pendTarget_reg;
        calCnt_next = calCnt_reg;
        adcStart_next = 1'b0;
        adcChannel_next = adcChannel_reg;
        adcCalibrate_next = adcCalibrate_reg;
        adcPowerDown_next = adcPowerDown_reg;
        slotDone_next = 1'b0;
        sampleActive_next = sampleActive_reg;
        halted_next = halted_reg;

        if (branchEff) begin
            pendJump_next = 1'b1;
            pendTarget_next = jumpTargetSlot;
        end

        case (state_reg)
            ST_ISSUE: begin
                follow_next = slotPlusOne;
                haltAfter_next = 1'b0;
                case (slotOp)
                    OP_SAMPLE, OP_SAMPLE_JUMP: begin
                        adcStart_next = 1'b1;
                        adcChannel_next = slotChan;
                        sampleActive_next = 1'b1;
                        if (slotOp == OP_SAMPLE_JUMP) begin
                            follow_next = slotTarget;
                        end
                        state_next = ST_CONVERT;
                    end
                    OP_CALIBRATE, OP_CALIBRATE_JUMP: begin
                        adcCalibrate_next = 1'b1;
                        adcPowerDown_next = 1'b0;
                        calCnt_next = CAL_LOAD;
                        if (slotOp == OP_CALIBRATE_JUMP) begin
                            follow_next = slotTarget;
                        end
                        state_next = ST_CALIBRATE;
                    end
                    OP_JUMP: begin
                        follow_next = slotTarget;
                        state_next = ST_FINISH;
                    end
                    OP_POWER_DOWN: begin
                        adcPowerDown_next = 1'b1;
                        powered_next = 1'b1;
                        haltAfter_next = 1'b1;
                        state_next = ST_FINISH;
                    end
                    OP_STOP: begin
                        haltAfter_next = 1'b1;
                        state_next = ST_FINISH;
                    end
                    default: begin
                        state_next = ST_FINISH;
                    end
                endcase
            end
            ST_CONVERT: begin
                if (adcDone) begin
                    sampleActive_next = 1'b0;
                    state_next = ST_FINISH;
                end
            end
            ST_CALIBRATE: begin
                if (calCnt_reg <= CAL_CNT_ONE) begin
                    calCnt_next = CAL_CNT_RESET;
                    adcCalibrate_next = 1'b0;
                    powered_next = 1'b0;
                    state_next = ST_FINISH;
                end else begin
                    calCnt_next = calCnt_reg - CAL_CNT_ONE;
                end
            end
            ST_FINISH: begin
                slotDone_next = 1'b1;
                pendJump_next = 1'b0;
                if (jumpWanted) begin
                    slot_next = jumpSlot;
                    halted_next = 1'b0;
                    state_next = manualMode ? ST_WAIT_TRIG : ST_ISSUE;
                end else begin
                    slot_next = follow_reg;
                    if (haltAfter_reg) begin
                        slot_next = slot_reg;
                        halted_next = 1'b1;
                        state_next = ST_HALTED;
                    end else if (manualMode) begin
                        state_next = ST_WAIT_TRIG;
                    end else begin
                        state_next = ST_ISSUE;
                    end
                end
            end
            ST_WAIT_TRIG: begin
                if (jumpWanted) begin
                    pendJump_next = 1'b0;
                    slot_next = jumpSlot;
                    state_next = ST_ISSUE;
                end else if (trigEff || !manualMode) begin
                    state_next = ST_ISSUE;
                end
            end
            ST_HALTED: begin
                if (jumpWanted) begin
                    pendJump_next = 1'b0;
                    slot_next = jumpSlot;
                    halted_next = 1'b0;
                    state_next = ST_ISSUE;
                end else if (trigEff && !powered_reg) begin
                    slot_next = follow_reg;
                    halted_next = 1'b0;
                    state_next = ST_ISSUE;
                end
            end
            default: begin
                state_next = ST_HALTED;
            end
        endcase
    end

    // ***************************************************
    // Registers
    // ***************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_ISSUE;
            slot_reg <= RESET_SLOT;
            follow_reg <= RESET_SLOT;
            haltAfter_reg <= 1'b0;
            powered_reg <= 1'b0;
            pendJump_reg <= 1'b0;
            pendTarget_reg <= RESET_SLOT;
            calCnt_reg <= CAL_CNT_RESET;
            adcStart_reg <= 1'b0;
            adcChannel_reg <= CHAN_RESET;
            adcCalibrate_reg <= 1'b0;
            adcPowerDown_reg <= 1'b0;
            slotDone_reg <= 1'b0;
            sampleActive_reg <= 1'b0;
            halted_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            slot_reg <= slot_next;
            follow_reg <= follow_next;
            haltAfter_reg <= haltAfter_next;
            powered_reg <= powered_next;
            pendJump_reg <= pendJump_next;
            pendTarget_reg <= pendTarget_next;
            calCnt_reg <= calCnt_next;
            adcStart_reg <= adcStart_next;
            adcChannel_reg <= adcChannel_next;
            adcCalibrate_reg <= adcCalibrate_next;
            adcPowerDown_reg <= adcPowerDown_next;
            slotDone_reg <= slotDone_next;
            sampleActive_reg <= sampleActive_next;
            halted_reg <= halted_next;
        end
    end

    // ***************************************************
    // Outputs
    // ***************************************************
    // executing slot shown
    assign slotNumber = slot_reg;
    assign adcStart = adcStart_reg;
    assign adcChannel = adcChannel_reg;
    assign adcCalibrate = adcCalibrate_reg;
    assign adcPowerDown = adcPowerDown_reg;
    assign slotDone = slotDone_reg;
    assign sampleActive = sampleActive_reg;
    assign halted = halted_reg;
    assign conversionResult = resBus.result;
    assign resultValid = resBus.valid;
endmodule // ssq_slot_sequencer

//--- dv/ssq_adc_model.sv
// Behavioural converter answering the sequencer's start pulses
`timescale 1ns/1ns
module ssq_adc_model
    import ssq_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Converter control
    input wire logic adcStart,
    input wire logic [CHAN_W-1:0] adcChannel,
    input wire logic [3:0] lag,
    // Converter answer
    output logic adcDone,
    output logic [RES_W-1:0] adcData
);
    int waitCnt;

    initial begin
        adcDone = 1'b0;
        adcData = 12'h5A3;
        waitCnt = -1;
    end

    always @(negedge clock) begin
        adcDone <= 1'b0;
        // Data line toggles outside a result
        adcData <= ~adcData;
        if (!rst_b) begin
            waitCnt <= -1;
        end else if (adcStart) begin
            waitCnt <= int'(lag);
        end else if (waitCnt == 0) begin
            adcDone <= 1'b1;
            adcData <= {adcChannel, 7'($urandom)};
            waitCnt <= -1;
        end else if (waitCnt > 0) begin
            waitCnt <= waitCnt - 1;
        end
    end
endmodule // ssq_adc_model

//--- dv/ssq_slot_sequencer_monitor.sv
// Assertion checker for the slot sequencer ports
`timescale 1ns/1ns
module ssq_slot_sequencer_monitor
    import ssq_pkg::*;
#(
    parameter int CAL_CYCLES = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Inputs
    input wire logic [1:0] resMode,
    input wire logic extTrigger,
    input wire logic branchRequest,
    input wire logic adcDone,
    input wire logic [RES_W-1:0] adcData,
    // Outputs
    input wire logic adcStart,
    input wire logic adcCalibrate,
    input wire logic adcPowerDown,
    input wire logic [SLOT_W-1:0] slotNumber,
    input wire logic slotDone,
    input wire logic sampleActive,
    input wire logic halted,
    input wire logic [RES_W-1:0] conversionResult,
    input wire logic resultValid
);
    int calLen;

    function automatic logic [RES_W-1:0] maskOf(input logic [1:0] m);
        case (m)
            RES_MODE_10: return MASK_10;
            RES_MODE_8: return MASK_8;
            default: return MASK_12;
        endcase
    endfunction

    // Length of the running calibration
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) calLen <= 0;
        else calLen <= adcCalibrate ? calLen + 1 : 0;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence convEnd;
        adcDone && sampleActive && !adcPowerDown;
    endsequence
    sequence resultOut;
        resultValid && !sampleActive ##1 slotDone;
    endsequence

    start_pulse_a: assert property (adcStart |=> !adcStart)
        else $error("start pulse too long");
    start_once_a: assert property (
        adcStart |-> sampleActive && !$past(sampleActive))
        else $error("start during a conversion");
    start_steady_a: assert property (
        adcStart |-> $stable(slotNumber))
        else $error("slot moved at start");
    sample_end_a: assert property (
        $fell(sampleActive) |-> $past(adcDone))
        else $error("sample ended without done");
    result_seq_a: assert property (convEnd |=> resultOut)
        else $error("result or slot end missing");
    result_mask_a: assert property (
        resultValid |-> conversionResult ==
            ($past(adcData) & maskOf($past(resMode))))
        else $error("result bits wrong");
    valid_pulse_a: assert property (resultValid |=> !resultValid)
        else $error("result valid too long");
    cal_length_a: assert property (
        $fell(adcCalibrate) |-> calLen == CAL_CYCLES)
        else $error("calibration length wrong");
    cal_bound_a: assert property (calLen <= CAL_CYCLES)
        else $error("calibration too long");
    halt_hold_a: assert property (
        halted && !extTrigger && !branchRequest && !$past(extTrigger)
            && !$past(branchRequest) |=> $stable(slotNumber))
        else $error("halted sequencer moved");
endmodule // ssq_slot_sequencer_monitor

bind ssq_slot_sequencer ssq_slot_sequencer_monitor #(
    .CAL_CYCLES(CAL_CYCLES)
) ssq_slot_sequencer_monitor_i (
    .clock, .rst_b, .resMode, .extTrigger, .branchRequest, .adcDone,
    .adcData, .adcStart, .adcCalibrate, .adcPowerDown, .slotNumber,
    .slotDone, .sampleActive, .halted, .conversionResult, .resultValid
);

//--- dv/test_ssq_slot_sequencer.sv
// Self-checking bench for the slot sequencer
`timescale 1ns/1ns
module test_ssq_slot_sequencer
    import ssq_pkg::*;
;
    localparam int CAL = 8;
    localparam int LIMIT = 20000;
    logic clock, rst_b, ce, progWrEn, manualMode, extTrigger, branchRequest;
    logic [SLOT_W-1:0] progWrAddr, jumpTargetSlot, slotNumber;
    logic [SLOT_W-1:0] prevSlot, expSlot, pendTg;
    logic [WORD_W-1:0] progWrData;
    logic [1:0] resMode;
    logic adcDone, adcStart, adcCalibrate, adcPowerDown, slotDone;
    logic sampleActive, halted, resultValid, pend, pdn;
    logic [RES_W-1:0] adcData, conversionResult, lastData;
    logic [CHAN_W-1:0] adcChannel;
    logic [3:0] lag;
    logic [OP_W-1:0] progOp [SLOT_COUNT];
    logic [CHAN_W-1:0] progCh [SLOT_COUNT];
    logic [SLOT_W-1:0] progTg [SLOT_COUNT];
    int n_mismatch, num_checks, cyc;
    // Program table: slot, op code, target
    int adr [17] = '{0, 1, 2, 3, 4, 10, 11, 13, 15, 16, 17, 20, 21, 22, 23,
        62, 63};
    int ops [17] = '{2, 0, 7, 0, 1, 0, 3, 4, 6, 0, 5, 0, 2, 0, 4, 0, 7};
    int tgs [17] = '{0, 0, 0, 0, 1, 0, 13, 15, 0, 0, 0, 0, 0, 0, 62, 0, 0};

    ssq_slot_sequencer #(.CAL_CYCLES(CAL)) ssq_slot_sequencer_i (.*);
    ssq_adc_model ssq_adc_model_i (.*);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ***************************************************
    // Tasks
    // ***************************************************
    task automatic chk(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic put(input int a, input logic [OP_W-1:0] op, input int t);
        progOp[a] = op;
        progCh[a] = CHAN_W'($urandom);
        progTg[a] = SLOT_W'(t);
        progWrAddr = SLOT_W'(a);
        progWrData = {op, progCh[a], progTg[a]};
        progWrEn = 1'b1;
        @(negedge clock);
    endtask

    // Waits for n slot ends, new random mode and lag after each
    task automatic run(input int n);
        int t;
        repeat (n) begin
            t = 0;
            @(negedge clock);
            while (slotDone !== 1'b1 && t < 400) begin
                @(negedge clock);
                t++;
            end
            chk(t < 400, "no slot end");
            resMode = 2'($urandom);
            lag = 4'($urandom);
        end
    endtask

    task automatic wait_active();
        int t;
        t = 0;
        while (sampleActive !== 1'b1 && t < 400) begin
            @(negedge clock);
            t++;
        end
        chk(t < 400, "no sample");
    endtask

    task automatic poke(input bit br, input int t);
        branchRequest = br;
        extTrigger = !br;
        jumpTargetSlot = SLOT_W'(t);
        @(negedge clock);
        branchRequest = 1'b0;
        extTrigger = 1'b0;
    endtask

    function automatic logic [RES_W-1:0] fmt(input logic [RES_W-1:0] d,
        input logic [1:0] m);
        case (m)
            2'h1: return d & 12'hFFC;
            2'h2: return d & 12'hFF0;
            default: return d;
        endcase
    endfunction

    // ***************************************************
    // Tracker of slot order, channels and results
    // ***************************************************
    always @(negedge clock) begin
        if (!rst_b) begin
            pend = 1'b0;
            pdn = 1'b0;
        end else begin
            if (adcDone) lastData = adcData;
            if (adcStart) chk(adcChannel === progCh[slotNumber] &&
                progOp[slotNumber] <= OP_SAMPLE_JUMP, "bad channel");
            if (resultValid) chk(!pdn && conversionResult ===
                fmt(lastData, resMode), "bad result");
            if (slotDone) begin
                case (progOp[prevSlot])
                    OP_SAMPLE_JUMP, OP_CALIBRATE_JUMP, OP_JUMP:
                        expSlot = progTg[prevSlot];
                    OP_POWER_DOWN, OP_STOP: expSlot = prevSlot;
                    default: expSlot = prevSlot + 6'h01;
                endcase
                if (pend) expSlot = pendTg;
                chk(slotNumber === expSlot, "slot order");
                chk(halted === (!pend && (progOp[prevSlot] == OP_STOP ||
                    progOp[prevSlot] == OP_POWER_DOWN)), "halt");
                if (progOp[prevSlot] == OP_POWER_DOWN) pdn = 1'b1;
                if (progOp[prevSlot] inside {OP_CALIBRATE, OP_CALIBRATE_JUMP})
                    pdn = 1'b0;
                pend = 1'b0;
            end
        end
        prevSlot = slotNumber;
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            close_out();
        end
    end

    // ***************************************************
    // Main sequence
    // ***************************************************
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        manualMode = 1'b0;
        progWrEn = 1'b0;
        progWrAddr = 6'h00;
        progWrData = 14'h0000;
        extTrigger = 1'b0;
        branchRequest = 1'b0;
        jumpTargetSlot = 6'h00;
        resMode = 2'h0;
        lag = 4'h2;
        void'($urandom(9));
        @(negedge clock);
        foreach (adr[k]) put(adr[k], OP_W'(ops[k]), tgs[k]);
        progWrEn = 1'b0;
        rst_b = 1'b1;
        chk(slotNumber === 6'h00, "not at slot 0");
        run(9);
        $display("test start_and_loop done");
        wait_active();
        pend = 1'b1;
        pendTg = 6'h0A;
        poke(1'b1, 10);
        run(5);
        chk(halted === 1'b1 && slotNumber === 6'h0F, "no stop");
        repeat (6) @(negedge clock);
        chk(slotNumber === 6'h0F, "left stop");
        poke(1'b0, 0);
        repeat (2) @(negedge clock);
        chk(slotNumber === 6'h10, "no restart");
        run(2);
        chk(adcPowerDown === 1'b1 && halted === 1'b1, "no power down");
        poke(1'b0, 0);
        repeat (4) @(negedge clock);
        chk(slotNumber === 6'h11, "trigger woke power down");
        $display("test branch_stop_power done");
        poke(1'b1, 20);
        repeat (2) @(negedge clock);
        chk(slotNumber === 6'h14, "no branch from halt");
        run(8);
        $display("test recal_and_wrap done");
        wait_active();
        rst_b = 1'b0;
        @(negedge clock);
        chk(slotNumber === 6'h00 && sampleActive === 1'b0, "reset");
        rst_b = 1'b1;
        run(24);
        $display("test reset_and_random done");
        // Manual stepping, then a frozen clock enable while waiting
        manualMode = 1'b1;
        run(1);
        repeat (5) @(negedge clock);
        chk({slotNumber, sampleActive} === 7'h02, "no wait");
        poke(1'b0, 0);
        wait_active();
        chk(slotNumber === 6'h01, "trigger lost");
        run(1);
        @(negedge clock);
        ce = 1'b0;
        poke(1'b0, 0);
        repeat (3) @(negedge clock);
        chk({slotNumber, sampleActive} === 7'h04, "not frozen");
        ce = 1'b1;
        manualMode = 1'b0;
        run(2);
        $display("test manual_and_freeze done");
        close_out();
    end
endmodule // test_ssq_slot_sequencer
